// File: pkg/dtw_pkg.sv
package dtw_pkg;

  // Counter and compare width
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // Wave generation modes, Gray ordered
  typedef enum logic [1:0] {
    DTW_ONE_RAMP  = 2'h0,
    DTW_TWO_RAMP  = 2'h1,
    DTW_FOUR_RAMP = 2'h3,
    DTW_DUAL      = 2'h2
  } dtw_mode_t;

  // Cycle phases: dead A, on A, dead B, on B
  typedef enum logic [1:0] {
    DTW_PH_DTA = 2'h0,
    DTW_PH_OTA = 2'h1,
    DTW_PH_DTB = 2'h3,
    DTW_PH_OTB = 2'h2
  } dtw_phase_t;

  // Double-buffered byte registers, index into the buffer array
  localparam int BUF_N = 12;
  localparam logic [3:0] BI_ASET_L = 4'h0;
  localparam logic [3:0] BI_ASET_H = 4'h1;
  localparam logic [3:0] BI_ACLR_L = 4'h2;
  localparam logic [3:0] BI_ACLR_H = 4'h3;
  localparam logic [3:0] BI_BSET_L = 4'h4;
  localparam logic [3:0] BI_BSET_H = 4'h5;
  localparam logic [3:0] BI_BCLR_L = 4'h6;
  localparam logic [3:0] BI_BCLR_H = 4'h7;
  localparam logic [3:0] BI_DLY_CTRL = 4'h8;
  localparam logic [3:0] BI_DLY_VAL = 4'h9;
  localparam logic [3:0] BI_DITHER = 4'ha;
  localparam logic [3:0] BI_DEBUG = 4'hb;
  localparam logic [7:0] BUF_RST = 8'h00;

  // Delay control fields
  localparam int DLY_SEL_LSB = 0;
  localparam int DLY_TRIG_LSB = 2;
  localparam int DLY_PRESC_LSB = 4;
  localparam logic [1:0] DLY_SEL_BLANK = 2'h1;
  localparam logic [1:0] DLY_SEL_EVENT = 2'h2;

  // Delay trigger sources
  localparam logic [1:0] DLY_TRIG_A_ON = 2'h0;
  localparam logic [1:0] DLY_TRIG_A_OFF = 2'h1;
  localparam logic [1:0] DLY_TRIG_B_ON = 2'h2;
  localparam logic [1:0] DLY_TRIG_B_OFF = 2'h3;

  // Digital filter length in clock cycles
  localparam logic [2:0] FILT_LEN = 3'h4;

endpackage

// File: rtl/dtw_evt_in.sv
module dtw_evt_in
  import dtw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Event
  input wire logic evt_in,
  input wire logic filter_en,
  output logic evt_out
);

  logic sync1_q;
  logic sync2_q;
  logic filt_q;
  logic filt_d;
  logic [2:0] fcnt_q;
  logic [2:0] fcnt_d;

  always_comb begin
    filt_d = filt_q;
    fcnt_d = 3'h0;
    if (sync2_q != filt_q) begin
      if (fcnt_q == FILT_LEN - 3'h1) begin
        filt_d = sync2_q;
      end else begin
        fcnt_d = fcnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      filt_q <= 1'b0;
      fcnt_q <= 3'h0;
    end else begin
      sync1_q <= evt_in;
      sync2_q <= sync1_q;
      filt_q <= filt_d;
      fcnt_q <= fcnt_d;
    end
  end

  assign evt_out = filter_en ? filt_q : sync2_q;

  a_filter_reject: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(filt_q) |-> $past(sync2_q, 1) && $past(sync2_q, 2) && $past(sync2_q, 3)
      && $past(sync2_q, 4))
    else $error("filtered event rose without four stable cycles");

endmodule

// File: rtl/dtw_wave_core.sv
// Function
// - Static configuration writes are ignored while run is set.
// - Mode and event control bits form the static configuration.
// - Clearing status and capture values needs no synchronisation wait.
// - One-ramp counts from zero to b_fall, then restarts at zero.
// - One-ramp: values above b_fall never match; a_fall below a_rise ignored.
// - Two-ramp counts to a_fall, resets, counts to b_fall, restarts.
// - Two-ramp never lets outputs A and B be active together.
// - Four-ramp runs four up-counts per cycle, outputs never overlap.
// - Dual-slope counts down from b_fall to zero, then back up.
// - Dual-slope A rises on up-count match, falls on down-count match.
// - Dual-slope B rises on down-count match, falls on up-count match.
// - Dual-slope ignores a_fall_value entirely.
// - Dual-slope starts at b_fall counting down; A idle for first cycle.
// - Events act only with trigger enable; capture also needs action bit.
// - Blanking applies to input A only; B otherwise identical.
// - Synchronised events reach outputs in 2-3 cycles; detect_a overrides at once.
// - Blanking is on when delay select is 1; trigger field picks start.
// - Prescaled delay counter counts to delay value, masking input A meanwhile when blanking is selected.
// - Blanking and delayed output event share one delay counter.
// - With filter set, input changes shorter than 4 cycles are rejected.
// - Detect_a detect overrides the output for the whole event, however short.
// - Buffers move on sync command or enable; written only when ready.
// - A two- or four-ramp cycle runs dead A, on A, dead B, on B without overlap.
module dtw_wave_core
  import dtw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Enable and commands
  input wire logic enable_wr,
  input wire logic enable_data,
  input wire logic sync_cmd,
  input wire logic clear_status,
  // Static configuration
  input wire logic static_wr,
  input wire logic [1:0] wave_mode_cfg,
  input wire logic [1:0] trigger_input_enable_cfg,
  input wire logic [1:0] capture_action_cfg,
  input wire logic [1:0] filter_cfg,
  input wire logic [1:0] detect_a_cfg,
  // Double-buffered byte writes
  input wire logic buf_wr,
  input wire logic [3:0] buf_sel,
  input wire logic [7:0] buf_data,
  // Event inputs
  input wire logic [1:0] event_in,
  // Outputs
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic run,
  output logic command_ready,
  output logic delay_event,
  output logic [CNT_W-1:0] capture_a,
  output logic [CNT_W-1:0] capture_b,
  output logic [7:0] dither_value,
  output logic [7:0] debug_control
);

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  function automatic logic [CNT_W-1:0] cmp12(input logic [7:0] lo, input logic [7:0] hi);
    return {hi[3:0], lo};
  endfunction

  // Configuration and enable state
  logic run_q, run_d, init_q, init_d, sync_q, sync_d;
  dtw_mode_t mode_q, mode_d;
  logic [1:0] trig_en_q, trig_en_d, action_q, action_d;
  logic [1:0] filter_q, filter_d, detect_q, detect_d;
  logic [7:0] buf_q [BUF_N];
  logic [7:0] buf_d [BUF_N];
  logic [7:0] act_q [BUF_N];
  logic [7:0] act_d [BUF_N];

  assign command_ready = ~sync_q;

  always_comb begin
    run_d = run_q;
    init_d = 1'b0;
    sync_d = sync_cmd & run_q & ~sync_q;
    mode_d = mode_q;
    trig_en_d = trig_en_q;
    action_d = action_q;
    filter_d = filter_q;
    detect_d = detect_q;
    buf_d = buf_q;
    act_d = act_q;
    if (enable_wr) begin
      run_d = enable_data;
      init_d = enable_data & ~run_q;
    end
    // static bits only change while stopped
    // static set is mode and event control
    if (static_wr && !run_q) begin
      mode_d = dtw_mode_t'(wave_mode_cfg);
      trig_en_d = trigger_input_enable_cfg;
      action_d = capture_action_cfg;
      filter_d = filter_cfg;
      detect_d = detect_a_cfg;
    end
    if (buf_wr && command_ready && buf_sel < 4'(BUF_N)) begin
      buf_d[buf_sel] = buf_data;
    end
    if (sync_q || init_d) begin
      act_d = buf_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      init_q <= 1'b0;
      sync_q <= 1'b0;
      mode_q <= DTW_ONE_RAMP;
      trig_en_q <= 2'h0;
      action_q <= 2'h0;
      filter_q <= 2'h0;
      detect_q <= 2'h0;
      for (int i = 0; i < BUF_N; i++) begin
        buf_q[i] <= BUF_RST;
        act_q[i] <= BUF_RST;
      end
    end else begin
      run_q <= run_d;
      init_q <= init_d;
      sync_q <= sync_d;
      mode_q <= mode_d;
      trig_en_q <= trig_en_d;
      action_q <= action_d;
      filter_q <= filter_d;
      detect_q <= detect_d;
      buf_q <= buf_d;
      act_q <= act_d;
    end
  end

  assign run = run_q;
  assign dither_value = act_q[BI_DITHER];
  assign debug_control = act_q[BI_DEBUG];

  logic [CNT_W-1:0] aset, aclr, bset, bclr;
  assign aset = cmp12(act_q[BI_ASET_L], act_q[BI_ASET_H]);
  assign aclr = cmp12(act_q[BI_ACLR_L], act_q[BI_ACLR_H]);
  assign bset = cmp12(act_q[BI_BSET_L], act_q[BI_BSET_H]);
  assign bclr = cmp12(act_q[BI_BCLR_L], act_q[BI_BCLR_H]);

  // Wave generation state
  logic [CNT_W-1:0] cnt_q, cnt_d, tgt;
  dtw_phase_t ph_q, ph_d;
  logic down_q, down_d, first_q, first_d, a_q, a_d, b_q, b_d;

  always_comb begin
    cnt_d = cnt_q;
    ph_d = ph_q;
    down_d = down_q;
    first_d = first_q;
    a_d = a_q;
    b_d = b_q;
    tgt = bclr;
    if (!run_q) begin
      cnt_d = CNT_ZERO;
      ph_d = DTW_PH_DTA;
      down_d = 1'b0;
      first_d = 1'b1;
      a_d = 1'b0;
      b_d = 1'b0;
    end else if (init_q) begin
      // dual slope starts at b_fall counting down
      cnt_d = (mode_q == DTW_DUAL) ? bclr : CNT_ZERO;
      down_d = (mode_q == DTW_DUAL);
    end else begin
      unique case (mode_q)
        DTW_ONE_RAMP: begin
          // a_fall below a_rise has no effect
          if (cnt_q == aset) a_d = 1'b1;
          if (cnt_q == aclr && aclr > aset) a_d = 1'b0;
          if (cnt_q == bset) b_d = 1'b1;
          // wrap at b_fall, larger compares never reached
          if (cnt_q == bclr) begin
            cnt_d = CNT_ZERO;
            a_d = 1'b0;
            b_d = 1'b0;
          end else begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
        DTW_TWO_RAMP: begin
          // first ramp ends at a_fall, second at b_fall
          // each output lives in its own ramp only
          cnt_d = cnt_q + CNT_ONE;
          if (ph_q == DTW_PH_DTA || ph_q == DTW_PH_OTA) begin
            if (cnt_q == aset) begin
              a_d = 1'b1;
              ph_d = DTW_PH_OTA;
            end
            if (cnt_q == aclr) begin
              cnt_d = CNT_ZERO;
              a_d = 1'b0;
              ph_d = DTW_PH_DTB;
            end
          end else begin
            if (cnt_q == bset) begin
              b_d = 1'b1;
              ph_d = DTW_PH_OTB;
            end
            if (cnt_q == bclr) begin
              cnt_d = CNT_ZERO;
              b_d = 1'b0;
              ph_d = DTW_PH_DTA;
            end
          end
        end
        DTW_FOUR_RAMP: begin
          unique case (ph_q)
            DTW_PH_DTA: tgt = aset;
            DTW_PH_OTA: tgt = aclr;
            DTW_PH_DTB: tgt = bset;
            DTW_PH_OTB: tgt = bclr;
          endcase
          if (cnt_q == tgt) begin
            cnt_d = CNT_ZERO;
            unique case (ph_q)
              DTW_PH_DTA: ph_d = DTW_PH_OTA;
              DTW_PH_OTA: ph_d = DTW_PH_DTB;
              DTW_PH_DTB: ph_d = DTW_PH_OTB;
              DTW_PH_OTB: ph_d = DTW_PH_DTA;
            endcase
            a_d = (ph_d == DTW_PH_OTA);
            b_d = (ph_d == DTW_PH_OTB);
          end else begin
            cnt_d = cnt_q + CNT_ONE;
          end
        end
        DTW_DUAL: begin
          if (down_q) begin
            if (cnt_q == aset) a_d = 1'b0;
            if (cnt_q == bset) b_d = 1'b1;
            if (cnt_q == CNT_ZERO) begin
              down_d = 1'b0;
              cnt_d = CNT_ONE;
            end else begin
              cnt_d = cnt_q - CNT_ONE;
            end
          end else begin
            // no A during the first cycle
            if (cnt_q == aset && !first_q) a_d = 1'b1;
            if (cnt_q == bset) b_d = 1'b0;
            if (cnt_q == bclr) begin
              down_d = 1'b1;
              first_d = 1'b0;
              cnt_d = cnt_q - CNT_ONE;
            end else begin
              cnt_d = cnt_q + CNT_ONE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= CNT_ZERO;
      ph_q <= DTW_PH_DTA;
      down_q <= 1'b0;
      first_q <= 1'b1;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      down_q <= down_d;
      first_q <= first_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  // Shared delay counter for blanking and delayed output event
  logic [7:0] dctl;
  logic [1:0] dsel, dtrig;
  logic [2:0] div_m1, psc_q, psc_d;
  logic [7:0] dcnt_q, dcnt_d;
  logic drun_q, drun_d, devt_q, devt_d, dstart, blank_a;

  assign dctl = act_q[BI_DLY_CTRL];
  assign dsel = dctl[DLY_SEL_LSB +: 2];
  assign dtrig = dctl[DLY_TRIG_LSB +: 2];
  assign div_m1 = 3'((4'h1 << dctl[DLY_PRESC_LSB +: 2]) - 4'h1);

  always_comb begin
    unique case (dtrig)
      DLY_TRIG_A_ON: dstart = a_d & ~a_q;
      DLY_TRIG_A_OFF: dstart = a_q & ~a_d;
      DLY_TRIG_B_ON: dstart = b_d & ~b_q;
      DLY_TRIG_B_OFF: dstart = b_q & ~b_d;
    endcase
    drun_d = drun_q;
    dcnt_d = dcnt_q;
    psc_d = psc_q;
    devt_d = 1'b0;
    // one counter, mode picked by delay select
    // trigger field picks the start point
    if (dstart && (dsel == DLY_SEL_BLANK || dsel == DLY_SEL_EVENT)) begin
      drun_d = 1'b1;
      dcnt_d = 8'h00;
      psc_d = 3'h0;
    end else if (drun_q) begin
      // prescaled count up to delay value
      if (dcnt_q == act_q[BI_DLY_VAL]) begin
        drun_d = 1'b0;
        devt_d = (dsel == DLY_SEL_EVENT);
      end else if (psc_q == div_m1) begin
        psc_d = 3'h0;
        dcnt_d = dcnt_q + 8'h01;
      end else begin
        psc_d = psc_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      drun_q <= 1'b0;
      dcnt_q <= 8'h00;
      psc_q <= 3'h0;
      devt_q <= 1'b0;
    end else begin
      drun_q <= drun_d & run_q;
      dcnt_q <= dcnt_d;
      psc_q <= psc_d;
      devt_q <= devt_d;
    end
  end

  assign delay_event = devt_q;
  assign blank_a = drun_q & (dsel == DLY_SEL_BLANK);

  // Event inputs
  logic [1:0] evt, evt_prev_q, fault_q, fault_d, cap_hit;
  logic [CNT_W-1:0] cap_a_q, cap_a_d, cap_b_q, cap_b_d;

  for (genvar g = 0; g < 2; g++) begin : g_evt
    dtw_evt_in u_evt (
      .clk(clk),
      .reset_n(reset_n),
      .evt_in(event_in[g]),
      .filter_en(filter_q[g]),
      .evt_out(evt[g])
    );
  end

  always_comb begin
    // trigger enable gates fault, action gates capture
    fault_d = evt & trig_en_q & {1'b1, ~blank_a};
    cap_hit = fault_d & ~evt_prev_q & action_q;
    cap_a_d = cap_hit[0] ? cnt_q : cap_a_q;
    cap_b_d = cap_hit[1] ? cnt_q : cap_b_q;
    if (clear_status) begin
      cap_a_d = CNT_ZERO;
      cap_b_d = CNT_ZERO;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q <= 2'h0;
      evt_prev_q <= 2'h0;
      cap_a_q <= CNT_ZERO;
      cap_b_q <= CNT_ZERO;
    end else begin
      fault_q <= fault_d;
      evt_prev_q <= fault_d;
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
    end
  end

  assign capture_a = cap_a_q;
  assign capture_b = cap_b_q;

  // raw event bypasses the synchroniser so short pulses still block
  logic [1:0] detect_a_hit;
  assign detect_a_hit = event_in & detect_q & trig_en_q;
  assign pwm_out_a = a_q & ~fault_q[0] & ~detect_a_hit[0];
  assign pwm_out_b = b_q & ~fault_q[1] & ~detect_a_hit[1];

  a_static_hold: assert property (run_q && static_wr |=> $stable(mode_q) && $stable(trig_en_q))
    else $error("static configuration changed while running");
  a_one_wrap: assert property (run_q && !init_q && mode_q == DTW_ONE_RAMP
    && cnt_q == bclr |=> cnt_q == CNT_ZERO)
    else $error("one-ramp counter did not wrap at b_fall");
  a_two_apart: assert property (mode_q == DTW_TWO_RAMP |-> !(a_q && b_q))
    else $error("two-ramp outputs overlap");
  a_four_apart: assert property (mode_q == DTW_FOUR_RAMP |-> !(a_q && b_q))
    else $error("four-ramp outputs overlap");
  a_dual_turn: assert property (run_q && !init_q && mode_q == DTW_DUAL && down_q
    && cnt_q == CNT_ZERO |=> !down_q && cnt_q == CNT_ONE)
    else $error("dual-slope did not turn at zero");
  a_dual_first: assert property (run_q && mode_q == DTW_DUAL && first_q |-> !a_q)
    else $error("output A active in first dual-slope cycle");
  a_capture_gate: assert property ($changed(cap_a_q) && !$past(clear_status)
    |-> $past(action_q[0]) && $past(trig_en_q[0]))
    else $error("capture A without trigger enable and action");
  a_blank_mask: assert property (blank_a |=> !fault_q[0])
    else $error("input A passed during blanking");
  a_detect_a_over: assert property (detect_a_hit[1] |-> !pwm_out_b)
    else $error("detect_a event did not override output B");
  a_ready_xfer: assert property (sync_q |-> !command_ready ##1 command_ready)
    else $error("command ready not restored after transfer");

endmodule

// File: tb/dtw_evt_src.sv
module dtw_evt_src (
  // Clock
  input wire logic clk,
  // Switching stage view of the outputs
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic check_en,
  // Event lines and overlap count
  output logic [1:0] event_in,
  output logic [15:0] n_overlap
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] held [2];

  initial begin
    event_in = 2'h0;
    n_overlap = 16'h0;
    held[0] = 16'h0;
    held[1] = 16'h0;
  end

  // Held time counts rising edges, so the release point is free of races
  always @(posedge clk) begin
    held[0] <= event_in[0] ? held[0] + 16'h1 : 16'h0;
    held[1] <= event_in[1] ? held[1] + 16'h1 : 16'h0;
  end

  always @(negedge clk) begin
    if (check_en && pwm_out_a === 1'b1 && pwm_out_b === 1'b1) begin
      n_overlap <= n_overlap + 16'h1;
    end
  end

  task automatic raise(input int idx);
    event_in[idx] = 1'b1;
  endtask

  // an event is never released before three cycles
  task automatic drop(input int idx);
    while (held[idx] < 16'h3) begin
      @(negedge clk);
    end
    event_in[idx] = 1'b0;
  endtask
endmodule

// File: tb/tb_dtw_wave_core.sv
module tb_dtw_wave_core
  import dtw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, reset_n, enable_wr, enable_data, sync_cmd, clear_status, static_wr, buf_wr;
  logic [1:0] wave_mode_cfg, trigger_input_enable_cfg, capture_action_cfg, filter_cfg;
  logic [1:0] detect_a_cfg, event_in;
  logic [3:0] buf_sel;
  logic [7:0] buf_data;
  logic pwm_out_a, pwm_out_b, run, command_ready, ovl_en, delay_event;
  logic [7:0] dither_value, debug_control;
  logic [CNT_W-1:0] capture_a, capture_b;
  logic [15:0] n_overlap, hi, per;
  int n_errors, tests_run, n;

  dtw_wave_core u_dut (.clk(clk), .reset_n(reset_n), .enable_wr(enable_wr),
    .enable_data(enable_data), .sync_cmd(sync_cmd), .clear_status(clear_status),
    .static_wr(static_wr), .wave_mode_cfg(wave_mode_cfg),
    .trigger_input_enable_cfg(trigger_input_enable_cfg),
    .capture_action_cfg(capture_action_cfg), .filter_cfg(filter_cfg),
    .detect_a_cfg(detect_a_cfg), .buf_wr(buf_wr), .buf_sel(buf_sel), .buf_data(buf_data),
    .event_in(event_in), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .run(run),
    .command_ready(command_ready), .delay_event(delay_event), .capture_a(capture_a),
    .capture_b(capture_b), .dither_value(dither_value), .debug_control(debug_control));

  dtw_evt_src u_src (.clk(clk), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
    .check_en(ovl_en), .event_in(event_in), .n_overlap(n_overlap));

  always #5 clk = ~clk;

  // Shoot-through watch only in the modes whose rules forbid overlap
  assign ovl_en = run && (wave_mode_cfg == DTW_TWO_RAMP || wave_mode_cfg == DTW_FOUR_RAMP);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic outv(input bit b);
    return b ? pwm_out_b : pwm_out_a;
  endfunction

  // no call sets detect_a detect and filter on the same input
  task automatic cfg(input logic [1:0] m, tr, ac, fl, dt);
    static_wr = 1'b1;
    wave_mode_cfg = m;
    trigger_input_enable_cfg = tr;
    capture_action_cfg = ac;
    filter_cfg = fl;
    detect_a_cfg = dt;
    @(negedge clk);
    static_wr = 1'b0;
  endtask

  task automatic en(input logic v);
    enable_wr = 1'b1;
    enable_data = v;
    @(negedge clk);
    enable_wr = 1'b0;
    repeat (3) @(negedge clk);
  endtask

  // One-cycle command pulses: synchronise and clear
  task automatic cmd(input logic s, input logic c);
    sync_cmd = s;
    clear_status = c;
    @(negedge clk);
    sync_cmd = 1'b0;
    clear_status = 1'b0;
  endtask

  // Single buffer byte; an idle edge follows so strobes never merge
  task automatic wr_buf(input logic [3:0] sel, input logic [7:0] d);
    buf_wr = 1'b1;
    buf_sel = sel;
    buf_data = d;
    @(negedge clk);
    buf_wr = 1'b0;
    @(negedge clk);
  endtask

  // Compares as {hi nibble, lo byte}, written back to back
  task automatic set_cmp(input logic [11:0] as, af, bs, bf);
    logic [11:0] v [4];
    v = '{as, af, bs, bf};
    buf_wr = 1'b1;
    for (int i = 0; i < 8; i++) begin
      buf_sel = 4'(i);
      buf_data = i[0] ? {4'h0, v[i/2][11:8]} : v[i/2][7:0];
      @(negedge clk);
    end
    buf_wr = 1'b0;
  endtask

  task automatic wait_rise(input bit b);
    n = 0;
    while (outv(b) !== 1'b0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    while (outv(b) !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
  endtask

  // High time and period of one output, in cycles
  task automatic meas(input bit b);
    logic lo_seen;
    wait_rise(b);
    hi = 16'h1;
    per = 16'h1;
    lo_seen = 1'b0;
    for (int k = 0; k < 300; k++) begin
      @(negedge clk);
      if (outv(b) === 1'b1 && lo_seen) break;
      if (outv(b) === 1'b1) hi++;
      else lo_seen = 1'b1;
      per++;
    end
  endtask

  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    enable_wr = 1'b0;
    enable_data = 1'b0;
    sync_cmd = 1'b0;
    clear_status = 1'b0;
    static_wr = 1'b0;
    buf_wr = 1'b0;
    buf_sel = 4'h0;
    buf_data = 8'h00;
    wave_mode_cfg = 2'h0;
    trigger_input_enable_cfg = 2'h0;
    capture_action_cfg = 2'h0;
    filter_cfg = 2'h0;
    detect_a_cfg = 2'h0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    chk({12'h0, run, command_ready, pwm_out_a, pwm_out_b}, 16'h4);
    chk({4'h0, capture_a}, 16'h0);
    set_cmp(12'h002, 12'h005, 12'h008, 12'h00c);
    cfg(DTW_ONE_RAMP, 2'h0, 2'h0, 2'h0, 2'h0);
    en(1'b1);
    chk({15'h0, run}, 16'h1);
    meas(1'b0);
    chk(hi, 16'd3);
    chk(per, 16'd13);
    meas(1'b1);
    chk(hi, 16'd4);
    // Mode change while running must be dropped
    cfg(DTW_TWO_RAMP, 2'h0, 2'h0, 2'h0, 2'h0);
    meas(1'b0);
    chk(per, 16'd13);
    en(1'b0);
    cfg(DTW_TWO_RAMP, 2'h0, 2'h0, 2'h0, 2'h0);
    en(1'b1);
    meas(1'b0);
    chk(hi, 16'd3);
    chk(per, 16'd19);
    meas(1'b1);
    chk(hi, 16'd4);
    en(1'b0);
    cfg(DTW_FOUR_RAMP, 2'h0, 2'h0, 2'h0, 2'h0);
    en(1'b1);
    meas(1'b0);
    chk(hi, 16'd6);
    chk(per, 16'd31);
    meas(1'b1);
    chk(hi, 16'd13);
    en(1'b0);
    chk(n_overlap, 16'h0);
    cfg(DTW_DUAL, 2'h3, 2'h2, 2'h0, 2'h0);
    en(1'b1);
    n = 0;
    while (pwm_out_a !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, n > 24}, 16'h1);
    meas(1'b0);
    chk(hi, 16'd20);
    chk(per, 16'd24);
    meas(1'b1);
    chk(hi, 16'd16);
    // New values wait in the buffer until synchronised
    set_cmp(12'h002, 12'h009, 12'h006, 12'h00c);
    meas(1'b1);
    chk(hi, 16'd16);
    cmd(1'b1, 1'b0);
    chk({15'h0, command_ready}, 16'h0);
    repeat (3) @(negedge clk);
    meas(1'b1);
    chk(hi, 16'd12);
    meas(1'b0);
    chk(hi, 16'd20);
    // Synchronised fault on B, captured on B only
    wait_rise(1'b1);
    u_src.raise(1);
    repeat (2) @(negedge clk);
    chk({15'h0, pwm_out_b}, 16'h1);
    @(negedge clk);
    chk({15'h0, pwm_out_b}, 16'h0);
    u_src.drop(1);
    repeat (3) @(negedge clk);
    chk({15'h0, capture_b != 12'h0}, 16'h1);
    chk({4'h0, capture_a}, 16'h0);
    cmd(1'b0, 1'b1);
    @(negedge clk);
    chk({4'h0, capture_b}, 16'h0);
    en(1'b0);
    cfg(DTW_DUAL, 2'h1, 2'h0, 2'h1, 2'h0);
    en(1'b1);
    // B events are dead with the trigger enable off
    wait_rise(1'b1);
    u_src.raise(1);
    repeat (4) @(negedge clk);
    chk({15'h0, pwm_out_b}, 16'h1);
    u_src.drop(1);
    wait_rise(1'b0);
    u_src.raise(0);
    repeat (3) @(negedge clk);
    u_src.drop(0);
    repeat (6) @(negedge clk);
    chk({15'h0, pwm_out_a}, 16'h1);
    u_src.raise(0);
    repeat (6) @(negedge clk);
    chk({15'h0, pwm_out_a}, 16'h1);
    @(negedge clk);
    chk({15'h0, pwm_out_a}, 16'h0);
    u_src.drop(0);
    en(1'b0);
    cfg(DTW_DUAL, 2'h2, 2'h0, 2'h0, 2'h2);
    en(1'b1);
    wait_rise(1'b1);
    u_src.raise(1);
    #1;
    chk({15'h0, pwm_out_b}, 16'h0);
    u_src.drop(1);
    en(1'b0);
    // Blanking after A rises; dither and debug bytes move on enable
    wr_buf(BI_DLY_CTRL, 8'h01);
    wr_buf(BI_DLY_VAL, 8'h0a);
    wr_buf(BI_DITHER, 8'h5a);
    wr_buf(BI_DEBUG, 8'ha5);
    cfg(DTW_DUAL, 2'h1, 2'h0, 2'h0, 2'h0);
    en(1'b1);
    chk({8'h0, dither_value}, 16'h5a);
    chk({8'h0, debug_control}, 16'ha5);
    wait_rise(1'b0);
    u_src.raise(0);
    repeat (6) @(negedge clk);
    chk({15'h0, pwm_out_a}, 16'h1);
    repeat (8) @(negedge clk);
    chk({15'h0, pwm_out_a}, 16'h0);
    u_src.drop(0);
    // Same counter as delayed output event, loaded by a synchronise
    wr_buf(BI_DLY_CTRL, 8'h02);
    wr_buf(BI_DLY_VAL, 8'h03);
    cmd(1'b1, 1'b0);
    repeat (2) @(negedge clk);
    wait_rise(1'b0);
    repeat (3) @(negedge clk);
    chk({15'h0, delay_event}, 16'h0);
    @(negedge clk);
    chk({15'h0, delay_event}, 16'h1);
    @(negedge clk);
    chk({15'h0, delay_event}, 16'h0);
    en(1'b0);
    test_done();
  end
endmodule
